// >>> inc/mpr_pkg.sv
// shared constants, types and decode helpers of the main processor register block
package mpr_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int MPR_W = 16;
	localparam int MPR_BW = 8;
	localparam int MPR_LIDX_W = 4;
	localparam int MPR_LREG_N = 16;
	localparam int MPR_SYS_W = 9;
	localparam int MPR_MIDX_W = 8;
	localparam int MPR_MAP_COUNT = 248;
	localparam int MPR_REAL_COUNT = 8;
	localparam int MPR_MAP_TOTAL = MPR_MAP_COUNT + MPR_REAL_COUNT;
	localparam int MPR_PHYS_W = 19;
	localparam int MPR_SAVE_W = 24;
	localparam int MPR_XPAGE_LSB = 11;
	localparam int MPR_RPAGE_LSB = 13;

	// ----------------------------------------------------------------
	// system addresses of the map groups and of the translation save high byte
	// ----------------------------------------------------------------
	localparam logic [8:0] MPR_SYS_MAP_LO = 9'h080;
	localparam logic [8:0] MPR_SYS_MAP_HI = 9'h17F;
	localparam logic [8:0] MPR_SYS_TASK1_BASE = 9'h080;
	localparam logic [8:0] MPR_SYS_REAL_BASE = 9'h0A0;
	localparam logic [8:0] MPR_SYS_IO1_BASE = 9'h0A8;
	localparam logic [8:0] MPR_SYS_TASK0_BASE = 9'h0C0;
	localparam logic [8:0] MPR_SYS_IO0_BASE = 9'h0E0;
	localparam logic [8:0] MPR_SYS_IO2_BASE = 9'h100;
	localparam logic [8:0] MPR_SYS_REG_HIGH = 9'h0A7;
	localparam logic [15:0] MPR_SYS_XSH = 16'h0010;

	// ----------------------------------------------------------------
	// local work register slots
	// ----------------------------------------------------------------
	localparam logic [3:0] MPR_LR_ARG1 = 4'h0;
	localparam logic [3:0] MPR_LR_ARG2 = 4'h1;
	localparam logic [3:0] MPR_LR_NEXT = 4'h2;
	localparam logic [3:0] MPR_LR_SNAP = 4'h3;
	localparam logic [3:0] MPR_LR_XR1 = 4'h4;
	localparam logic [3:0] MPR_LR_XR2 = 4'h5;
	localparam logic [3:0] MPR_LR_RECALL = 4'h6;
	localparam logic [3:0] MPR_LR_LEN = 4'h7;
	localparam logic [3:0] MPR_LR_WR4 = 4'h8;
	localparam logic [3:0] MPR_LR_XPTR = 4'hC;
	localparam logic [3:0] MPR_LR_RPTR = 4'hD;

	// ----------------------------------------------------------------
	// values
	// ----------------------------------------------------------------
	localparam logic [15:0] MPR_LREG_RST = 16'h0000;
	localparam logic [7:0] MPR_BYTE_RST = 8'h00;
	localparam logic [7:0] MPR_PROT_VALUE = 8'hFF;
	localparam logic [15:0] MPR_NO_SENSE = 16'h0000;

	typedef enum logic [1:0] {
		MPR_ST_IDLE = 2'b00,
		MPR_ST_LOOK = 2'b01,
		MPR_ST_ISSUE = 2'b10
	} mpr_state_e;

	// ----------------------------------------------------------------
	// internal address decode
	// ----------------------------------------------------------------
	function automatic logic mpr_is_local(input logic [15:0] a);
		mpr_is_local = (a[15:4] == 12'h000);
	endfunction

	function automatic logic mpr_is_map(input logic [15:0] a);
		mpr_is_map = (a >= {7'h00, MPR_SYS_MAP_LO}) && (a <= {7'h00, MPR_SYS_MAP_HI});
	endfunction

	function automatic logic [7:0] mpr_map_idx(input logic [8:0] sys);
		logic [8:0] d;
		d = sys - MPR_SYS_MAP_LO;
		mpr_map_idx = d[7:0];
	endfunction

endpackage

// >>> logic/mpr_local_regs.sv
// sixteen local work registers with instruction snapshot and length recall capture
`timescale 1ns/100ps
module mpr_local_regs
	import mpr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// word write
	input wire logic wr_en,
	input wire logic [MPR_LIDX_W-1:0] wr_idx,
	input wire logic [MPR_W-1:0] wr_data,
	// instruction start capture
	input wire logic snap_en,
	input wire logic [MPR_BW-1:0] snap_op,
	input wire logic [MPR_BW-1:0] snap_mod,
	// incomplete operation capture
	input wire logic recall_en,
	input wire logic [MPR_BW-1:0] recall_byte,
	// reads
	input wire logic [MPR_LIDX_W-1:0] rd_idx,
	output logic [MPR_W-1:0] rd_data,
	output logic [MPR_W-1:0] xptr,
	output logic [MPR_W-1:0] rptr
);

	logic [MPR_W-1:0] regs [MPR_LREG_N];
	logic [MPR_W-1:0] next_regs [MPR_LREG_N];

	// ----------------------------------------------------------------
	// next values
	// ----------------------------------------------------------------
	always_comb
	begin
		next_regs = regs;
		if (wr_en)
		begin
			next_regs[wr_idx] = wr_data;
		end
		if (recall_en)
		begin
			next_regs[MPR_LR_LEN] = {MPR_BYTE_RST, recall_byte};
		end
		// the recall slot is one byte wide, upper half always reads zero
		next_regs[MPR_LR_LEN][MPR_W-1:MPR_BW] = MPR_BYTE_RST;
		if (snap_en)
		begin
			next_regs[MPR_LR_SNAP] = {snap_op, snap_mod};
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < MPR_LREG_N; i++)
			begin
				regs[i] <= MPR_LREG_RST;
			end
		end
		else
		begin
			regs <= next_regs;
		end
	end

	assign rd_data = regs[rd_idx];
	assign xptr = regs[MPR_LR_XPTR];
	assign rptr = regs[MPR_LR_RPTR];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_SNAP_CAPTURE: assert property (@(posedge clk) disable iff (!nrst)
		snap_en |=> regs[MPR_LR_SNAP] == {$past(snap_op), $past(snap_mod)})
		else $error("snapshot not captured at instruction start");

	AST_LEN_CAPTURE: assert property (@(posedge clk) disable iff (!nrst)
		recall_en |=> regs[MPR_LR_LEN] == {MPR_BYTE_RST, $past(recall_byte)})
		else $error("length recall byte not captured");

endmodule

// >>> logic/mpr_map_bank.sv
// storage array of the address translation and real addressing map registers
`timescale 1ns/100ps
module mpr_map_bank
	import mpr_pkg::*;
(
	// clock
	input wire logic clk,
	// write port
	input wire logic wr_en,
	input wire logic [MPR_MIDX_W-1:0] wr_idx,
	input wire logic [MPR_BW-1:0] wr_data,
	// access read port
	input wire logic [MPR_MIDX_W-1:0] a_idx,
	output logic [MPR_BW-1:0] a_data,
	// sense read port
	input wire logic [MPR_MIDX_W-1:0] b_idx,
	output logic [MPR_BW-1:0] b_data,
	// high byte of the register save address
	output logic [MPR_BW-1:0] hold_data
);

	// map entries are plain storage, software loads them before use
	logic [MPR_BW-1:0] mem [MPR_MAP_TOTAL];

	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[wr_idx] <= wr_data;
		end
	end

	assign a_data = mem[a_idx];
	assign b_data = mem[b_idx];
	assign hold_data = mem[mpr_map_idx(MPR_SYS_REG_HIGH)];

endmodule

// >>> logic/mpr_main_regs.sv
// main processor local registers, translation maps and storage address latch
`timescale 1ns/100ps
module mpr_main_regs
	import mpr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// program writes to the local work registers
	input wire logic lsr_we,
	input wire logic [MPR_LIDX_W-1:0] lsr_idx,
	input wire logic [MPR_W-1:0] lsr_wdata,
	// instruction events
	input wire logic instr_start,
	input wire logic [MPR_BW-1:0] instr_op,
	input wire logic [MPR_BW-1:0] instr_mod,
	input wire logic op_incomplete,
	input wire logic [MPR_BW-1:0] op_r_byte,
	// mode guard levels
	input wire logic xlate_en,
	input wire logic privileged,
	input wire logic task_grp,
	// program writes to the map registers
	input wire logic map_we,
	input wire logic [MPR_SYS_W-1:0] map_sys,
	input wire logic [MPR_BW-1:0] map_wdata,
	// storage access request
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic [MPR_W-1:0] acc_addr,
	// logical address compare
	input wire logic cmp_en,
	input wire logic [MPR_W-1:0] cmp_addr,
	// control processor path
	input wire logic cp_latch_load,
	input wire logic [MPR_W-1:0] cp_latch_data,
	input wire logic cp_sense,
	input wire logic cp_load,
	input wire logic [MPR_W-1:0] cp_load_data,
	// storage side
	output logic acc_busy,
	output logic ms_valid,
	output logic ms_write,
	output logic [MPR_PHYS_W-1:0] ms_addr,
	output logic prot_err,
	output logic cmp_hit,
	// control processor answers
	output logic cp_sense_ack,
	output logic [MPR_W-1:0] cp_sense_data,
	output logic cp_latch_refused,
	output logic map_refused,
	// save area addresses
	output logic [MPR_SAVE_W-1:0] xlate_save_addr,
	output logic [MPR_SAVE_W-1:0] reg_save_addr
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	mpr_state_e state, next_state;
	logic [MPR_W-1:0] storage_addr_latch, next_latch;
	logic [MPR_BW-1:0] xlate_save_high_byte, next_xsh;
	logic acc_wr_q, next_acc_wr_q;
	logic next_busy, next_ms_valid, next_ms_write, next_prot_err, next_cmp_hit;
	logic [MPR_PHYS_W-1:0] next_ms_addr;
	logic next_sense_ack, next_latch_refused, next_map_refused;
	logic [MPR_W-1:0] next_sense_data;
	logic [MPR_SAVE_W-1:0] next_xsave, next_rsave;

	// ----------------------------------------------------------------
	// decode and write steering
	// ----------------------------------------------------------------
	logic sel_local, sel_map, sel_xsh;
	logic lr_wr_en;
	logic [MPR_LIDX_W-1:0] lr_wr_idx;
	logic [MPR_W-1:0] lr_wr_data, lr_rd, lr_xptr, lr_rptr;
	logic mb_wr_en, cp_map_wr, msp_map_ok;
	logic [MPR_MIDX_W-1:0] mb_wr_idx;
	logic [MPR_BW-1:0] mb_wr_data, map_a, map_b, map_hold;
	logic [MPR_SYS_W-1:0] a_sys;
	logic accept;

	assign sel_local = mpr_is_local(storage_addr_latch);
	assign sel_map = mpr_is_map(storage_addr_latch);
	assign sel_xsh = (storage_addr_latch == MPR_SYS_XSH);
	assign accept = (state == MPR_ST_IDLE) && acc_req;

	// control processor load wins the shared write port; a colliding program write is lost
	assign lr_wr_en = (cp_load && sel_local) || lsr_we;
	assign lr_wr_idx = (cp_load && sel_local) ? storage_addr_latch[MPR_LIDX_W-1:0] : lsr_idx;
	assign lr_wr_data = (cp_load && sel_local) ? cp_load_data : lsr_wdata;

	assign cp_map_wr = cp_load && sel_map;
	assign msp_map_ok = map_we && privileged && !cp_map_wr;
	assign mb_wr_en = cp_map_wr || msp_map_ok;
	assign mb_wr_idx = cp_map_wr ? mpr_map_idx(storage_addr_latch[MPR_SYS_W-1:0])
		: mpr_map_idx(map_sys);
	assign mb_wr_data = cp_map_wr ? cp_load_data[MPR_BW-1:0] : map_wdata;

	// translated pages are 2K, real pages 8K; both land in the same physical width
	always_comb
	begin
		if (xlate_en)
		begin
			a_sys = (task_grp ? MPR_SYS_TASK1_BASE : MPR_SYS_TASK0_BASE)
				+ {4'h0, storage_addr_latch[MPR_W-1:MPR_XPAGE_LSB]};
		end
		else
		begin
			a_sys = MPR_SYS_REAL_BASE + {6'h00, storage_addr_latch[MPR_W-1:MPR_RPAGE_LSB]};
		end
	end

	// ----------------------------------------------------------------
	// storage units
	// ----------------------------------------------------------------
	mpr_local_regs u_local (
		.clk(clk),
		.nrst(nrst),
		.wr_en(lr_wr_en),
		.wr_idx(lr_wr_idx),
		.wr_data(lr_wr_data),
		.snap_en(instr_start),
		.snap_op(instr_op),
		.snap_mod(instr_mod),
		.recall_en(op_incomplete),
		.recall_byte(op_r_byte),
		.rd_idx(storage_addr_latch[MPR_LIDX_W-1:0]),
		.rd_data(lr_rd),
		.xptr(lr_xptr),
		.rptr(lr_rptr)
	);

	mpr_map_bank u_maps (
		.clk(clk),
		.wr_en(mb_wr_en),
		.wr_idx(mb_wr_idx),
		.wr_data(mb_wr_data),
		.a_idx(mpr_map_idx(a_sys)),
		.a_data(map_a),
		.b_idx(mpr_map_idx(storage_addr_latch[MPR_SYS_W-1:0])),
		.b_data(map_b),
		.hold_data(map_hold)
	);

	// ----------------------------------------------------------------
	// access sequence and control processor answers
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_latch = storage_addr_latch;
		next_xsh = xlate_save_high_byte;
		next_acc_wr_q = acc_wr_q;
		next_ms_valid = 1'b0;
		next_ms_write = 1'b0;
		next_ms_addr = ms_addr;
		next_prot_err = 1'b0;
		next_cmp_hit = 1'b0;
		next_latch_refused = 1'b0;
		next_map_refused = map_we && !msp_map_ok;
		next_sense_ack = cp_sense;
		next_sense_data = cp_sense_data;
		case (state)
			MPR_ST_IDLE:
			begin
				if (acc_req)
				begin
					next_latch = acc_addr;
					next_acc_wr_q = acc_write;
					next_state = MPR_ST_LOOK;
				end
				else if (cp_latch_load)
				begin
					next_latch = cp_latch_data;
				end
			end
			MPR_ST_LOOK:
			begin
				next_state = MPR_ST_ISSUE;
				next_cmp_hit = xlate_en && cmp_en && (storage_addr_latch == cmp_addr);
				if (map_a == MPR_PROT_VALUE)
				begin
					next_prot_err = 1'b1;
				end
				else
				begin
					next_ms_valid = 1'b1;
					next_ms_write = acc_wr_q;
					if (xlate_en)
					begin
						next_ms_addr = {map_a, storage_addr_latch[MPR_XPAGE_LSB-1:0]};
					end
					else
					begin
						next_ms_addr = {map_a[5:0], storage_addr_latch[MPR_RPAGE_LSB-1:0]};
					end
				end
			end
			MPR_ST_ISSUE:
			begin
				next_state = MPR_ST_IDLE;
			end
			default:
			begin
				next_state = MPR_ST_IDLE;
			end
		endcase
		// the latch must not move under a running access
		if (cp_latch_load && (state != MPR_ST_IDLE || acc_req))
		begin
			next_latch_refused = 1'b1;
		end
		if (cp_load && sel_xsh)
		begin
			next_xsh = cp_load_data[MPR_BW-1:0];
		end
		if (cp_sense)
		begin
			if (sel_local)
			begin
				next_sense_data = lr_rd;
			end
			else if (sel_map)
			begin
				next_sense_data = {MPR_BYTE_RST, map_b};
			end
			else if (sel_xsh)
			begin
				next_sense_data = {MPR_BYTE_RST, xlate_save_high_byte};
			end
			else
			begin
				next_sense_data = MPR_NO_SENSE;
			end
		end
		next_busy = (next_state != MPR_ST_IDLE);
		next_xsave = {xlate_save_high_byte, lr_xptr};
		next_rsave = {map_hold, lr_rptr};
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state <= MPR_ST_IDLE;
			storage_addr_latch <= MPR_LREG_RST;
			xlate_save_high_byte <= MPR_BYTE_RST;
			acc_wr_q <= 1'b0;
			acc_busy <= 1'b0;
			ms_valid <= 1'b0;
			ms_write <= 1'b0;
			ms_addr <= '0;
			prot_err <= 1'b0;
			cmp_hit <= 1'b0;
			cp_sense_ack <= 1'b0;
			cp_sense_data <= MPR_NO_SENSE;
			cp_latch_refused <= 1'b0;
			map_refused <= 1'b0;
			xlate_save_addr <= '0;
			reg_save_addr <= '0;
		end
		else
		begin
			state <= next_state;
			storage_addr_latch <= next_latch;
			xlate_save_high_byte <= next_xsh;
			acc_wr_q <= next_acc_wr_q;
			acc_busy <= next_busy;
			ms_valid <= next_ms_valid;
			ms_write <= next_ms_write;
			ms_addr <= next_ms_addr;
			prot_err <= next_prot_err;
			cmp_hit <= next_cmp_hit;
			cp_sense_ack <= next_sense_ack;
			cp_sense_data <= next_sense_data;
			cp_latch_refused <= next_latch_refused;
			map_refused <= next_map_refused;
			xlate_save_addr <= next_xsave;
			reg_save_addr <= next_rsave;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	AST_BUSY_SPAN: assert property (
		accept |=> acc_busy [*2] ##1 !acc_busy)
		else $error("access busy span is not two cycles");

	AST_LATCH_HOLD: assert property (
		(state == MPR_ST_LOOK) |=> $stable(storage_addr_latch) ##1 $stable(storage_addr_latch))
		else $error("latch moved during a storage access");

	AST_PROTECT: assert property (
		(state == MPR_ST_LOOK) && (map_a == MPR_PROT_VALUE) |=> prot_err && !ms_valid)
		else $error("all-ones map entry did not block the access");

	AST_XLATE_ADDR: assert property (
		(state == MPR_ST_LOOK) && xlate_en && (map_a != MPR_PROT_VALUE)
		|=> ms_valid && (ms_addr == {$past(map_a), $past(storage_addr_latch[10:0])}))
		else $error("translated address not formed from map and latch");

	AST_REAL_ADDR: assert property (
		(state == MPR_ST_LOOK) && !xlate_en && (map_a != MPR_PROT_VALUE)
		|=> ms_addr[12:0] == $past(storage_addr_latch[12:0]))
		else $error("real address offset wrong");

	AST_CMP_GATED: assert property (
		!xlate_en |=> !cmp_hit)
		else $error("logical compare fired without translation");

	AST_NO_LATCH_SENSE: assert property (
		cp_sense && !sel_local && !sel_map && !sel_xsh |=> cp_sense_ack && cp_sense_data == 16'h0000)
		else $error("unmapped sense returned data");

	AST_MAP_GUARD: assert property (
		map_we && !privileged |=> map_refused)
		else $error("unprivileged map write not refused");

	AST_LATCH_REFUSE: assert property (
		cp_latch_load && (state != MPR_ST_IDLE) |=> cp_latch_refused && $stable(storage_addr_latch))
		else $error("latch load accepted during access");

	COV_PROTECTED: cover property (accept ##2 prot_err);
	COV_TRANSLATED: cover property (accept && xlate_en ##2 ms_valid);
	COV_SENSE_MAP: cover property (cp_sense && sel_map ##1 cp_sense_ack);

endmodule

// >>> tb/mpr_store_model.sv
// behavioural main storage: notes each issued access and each refusal
`timescale 1ns/100ps
module mpr_store_model
	import mpr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// access from the block
	input wire logic ms_valid,
	input wire logic [MPR_PHYS_W-1:0] ms_addr,
	input wire logic prot_err,
	// what storage saw
	output logic [MPR_PHYS_W-1:0] seen_addr,
	output int n_acc,
	output int n_prot
);
	// storage has no ready line, so every issued address is taken at once
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			n_acc <= 0;
			n_prot <= 0;
		end
		else if (ms_valid)
		begin
			seen_addr <= ms_addr;
			n_acc <= n_acc + 1;
		end
		else if (prot_err)
			n_prot <= n_prot + 1;
	end
endmodule

// >>> tb/mpr_main_regs_test.sv
// self-checking bench of the main processor register block
`timescale 1ns/100ps
module mpr_main_regs_test
	import mpr_pkg::*;
();
	// --------------------
	// signals and instances
	// --------------------
	logic clk, nrst, lsr_we, instr_start, op_incomplete, xlate_en, privileged, task_grp;
	logic map_we, acc_req, acc_write, cmp_en, cp_latch_load, cp_sense, cp_load;
	logic acc_busy, ms_valid, ms_write, prot_err, cmp_hit, cp_sense_ack, cp_latch_refused;
	logic map_refused;
	logic [3:0] lsr_idx;
	logic [7:0] instr_op, instr_mod, op_r_byte, map_wdata;
	logic [8:0] map_sys;
	logic [15:0] lsr_wdata, acc_addr, cmp_addr, cp_latch_data, cp_load_data, cp_sense_data, sd;
	logic [18:0] ms_addr, seen_addr;
	logic [23:0] xlate_save_addr, reg_save_addr;
	int n_acc, n_prot, n_mref, n_lref, n_fail, checks_done;

	mpr_main_regs dut_u (.clk, .nrst, .lsr_we, .lsr_idx, .lsr_wdata, .instr_start, .instr_op,
		.instr_mod, .op_incomplete, .op_r_byte, .xlate_en, .privileged, .task_grp, .map_we,
		.map_sys, .map_wdata, .acc_req, .acc_write, .acc_addr, .cmp_en, .cmp_addr,
		.cp_latch_load, .cp_latch_data, .cp_sense, .cp_load, .cp_load_data, .acc_busy,
		.ms_valid, .ms_write, .ms_addr, .prot_err, .cmp_hit, .cp_sense_ack, .cp_sense_data,
		.cp_latch_refused, .map_refused, .xlate_save_addr, .reg_save_addr);
	mpr_store_model st_u (.clk, .nrst, .ms_valid, .ms_addr, .prot_err, .seen_addr, .n_acc,
		.n_prot);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// refusals are single pulses, so they are counted rather than sampled
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			n_mref <= 0;
			n_lref <= 0;
		end
		else
		begin
			n_mref <= n_mref + int'(map_refused);
			n_lref <= n_lref + int'(cp_latch_refused);
		end
	end

	// --------------------
	// shared tasks
	// --------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic fail_wait();
		n_fail++;
		$display("[ERR] %0t wait ran out", $time);
		end_sim();
	endtask

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic lsr_wr(input logic [3:0] i, input logic [15:0] d);
		@(posedge clk);
		lsr_we <= 1'b1;
		lsr_idx <= i;
		lsr_wdata <= d;
		@(posedge clk);
		lsr_we <= 1'b0;
	endtask

	task automatic map_wr(input logic [8:0] s, input logic [7:0] d);
		@(posedge clk);
		map_we <= 1'b1;
		map_sys <= s;
		map_wdata <= d;
		@(posedge clk);
		map_we <= 1'b0;
	endtask

	task automatic latch(input logic [15:0] a);
		@(posedge clk);
		cp_latch_load <= 1'b1;
		cp_latch_data <= a;
		@(posedge clk);
		cp_latch_load <= 1'b0;
	endtask

	task automatic cp_ld(input logic [15:0] a, input logic [15:0] d);
		latch(a);
		cp_load <= 1'b1;
		cp_load_data <= d;
		@(posedge clk);
		cp_load <= 1'b0;
	endtask

	task automatic sense(input logic [15:0] a, output logic [15:0] d);
		latch(a);
		cp_sense <= 1'b1;
		@(posedge clk);
		cp_sense <= 1'b0;
		for (int n = 0; n < 4; n++)
		begin
			@(negedge clk);
			if (cp_sense_ack === 1'b1)
				break;
			if (n == 3)
				fail_wait();
			@(posedge clk);
		end
		d = cp_sense_data;
		@(posedge clk);
	endtask

	// poke tries to reload the latch while the access is still running
	task automatic access(input logic [15:0] a, input logic poke, output logic [18:0] got,
		output logic pe, output logic hit);
		@(posedge clk);
		acc_req <= 1'b1;
		acc_addr <= a;
		acc_write <= a[0];
		@(posedge clk);
		acc_req <= 1'b0;
		cp_latch_load <= poke;
		cp_latch_data <= ~a;
		for (int n = 0; n < 5; n++)
		begin
			@(posedge clk);
			cp_latch_load <= 1'b0;
			@(negedge clk);
			if ((ms_valid | prot_err) === 1'b1)
				break;
			if (n == 4)
				fail_wait();
		end
		got = ms_addr;
		pe = prot_err;
		hit = cmp_hit;
		check(24'(acc_busy), 24'h1);
		if (pe !== 1'b1)
			check(24'(ms_write), 24'(a[0]));
		repeat (2) @(posedge clk);
	endtask

	// --------------------
	// scenarios
	// --------------------
	task automatic s_local();
		logic [15:0] e;
		for (int i = 0; i < 16; i++)
			lsr_wr(4'(i), 16'hA50F ^ (16'(i) * 16'h1111));
		for (int i = 0; i < 16; i++)
		begin
			e = 16'hA50F ^ (16'(i) * 16'h1111);
			if (i == 7)
				e[15:8] = 8'h00;
			sense(16'(i), sd);
			check(24'(sd), 24'(e));
		end
	endtask

	task automatic s_snap();
		@(posedge clk);
		instr_start <= 1'b1;
		instr_op <= 8'h3C;
		instr_mod <= 8'h5A;
		lsr_we <= 1'b1;
		lsr_idx <= MPR_LR_SNAP;
		lsr_wdata <= 16'hFFFF;
		@(posedge clk);
		instr_start <= 1'b0;
		instr_op <= 8'h11;
		op_incomplete <= 1'b1;
		op_r_byte <= 8'h9D;
		lsr_idx <= MPR_LR_LEN;
		lsr_wdata <= 16'h1234;
		@(posedge clk);
		op_incomplete <= 1'b0;
		lsr_we <= 1'b0;
		sense(16'(MPR_LR_SNAP), sd);
		check(24'(sd), 24'h003C5A);
		sense(16'(MPR_LR_LEN), sd);
		check(24'(sd), 24'h00009D);
	endtask

	task automatic s_save();
		lsr_wr(MPR_LR_XPTR, 16'h1357);
		lsr_wr(MPR_LR_RPTR, 16'h2468);
		cp_ld(MPR_SYS_XSH, 16'h00C4);
		map_wr(MPR_SYS_REG_HIGH, 8'h6E);
		cp_ld(16'h0005, 16'hCAFE);
		sense(16'h0005, sd);
		check(24'(sd), 24'h00CAFE);
		check(xlate_save_addr, 24'hC41357);
		check(reg_save_addr, 24'h6E2468);
		sense(16'h0040, sd);
		check(24'(sd), 24'h0);
	endtask

	task automatic xl_case(input logic xl, input logic grp, input logic poke,
		input logic [15:0] a, input logic [7:0] m);
		logic [8:0] s;
		logic [18:0] got, e;
		logic pe, hit;
		int k, ka, kp;
		s = xl ? ((grp ? MPR_SYS_TASK1_BASE : MPR_SYS_TASK0_BASE) + 9'(a[15:11]))
			: MPR_SYS_REAL_BASE + 9'(a[15:13]);
		e = xl ? {m, a[10:0]} : {m[5:0], a[12:0]};
		xlate_en <= xl;
		task_grp <= grp;
		map_wr(s, m);
		sense(16'(s), sd);
		check(24'(sd), 24'(m));
		k = n_lref;
		ka = n_acc;
		kp = n_prot;
		access(a, poke, got, pe, hit);
		@(negedge clk);
		check(24'(n_lref - k), 24'(poke));
		check(24'(hit), 24'(xl & cmp_en & (cmp_addr == a)));
		check(24'(n_acc - ka), 24'(m != 8'hFF));
		check(24'(n_prot - kp), 24'(m == 8'hFF));
		if (m == 8'hFF)
			check(24'(pe), 24'h1);
		else
		begin
			check(24'(got), 24'(e));
			check(24'(seen_addr), 24'(e));
		end
		@(posedge clk);
	endtask

	task automatic s_refuse();
		int k;
		map_wr(MPR_SYS_MAP_HI, 8'h5C);
		privileged <= 1'b0;
		k = n_mref;
		map_wr(MPR_SYS_MAP_HI, 8'h12);
		repeat (2) @(posedge clk);
		@(negedge clk);
		check(24'(n_mref - k), 24'h1);
		sense(16'(MPR_SYS_MAP_HI), sd);
		check(24'(sd), 24'h00005C);
	endtask

	// --------------------
	// main sequence
	// --------------------
	initial
	begin
		{nrst, lsr_we, instr_start, op_incomplete, xlate_en, privileged, task_grp} = '0;
		{map_we, acc_req, acc_write, cmp_en, cp_latch_load, cp_sense, cp_load} = '0;
		{lsr_idx, lsr_wdata, instr_op, instr_mod, op_r_byte, map_sys, map_wdata} = '0;
		{acc_addr, cmp_addr, cp_latch_data, cp_load_data} = '0;
		{n_fail, checks_done} = '0;
		repeat (15) @(posedge clk);
		@(negedge clk);
		check(24'({acc_busy, ms_valid, prot_err, cmp_hit, cp_sense_ack, map_refused}), 24'h0);
		@(posedge clk);
		nrst <= 1'b1;
		sense(16'(MPR_LR_NEXT), sd);
		check(24'(sd), 24'h0);
		s_local();
		s_snap();
		privileged <= 1'b1;
		s_save();
		cmp_en <= 1'b1;
		cmp_addr <= 16'h2923;
		xl_case(1'b1, 1'b1, 1'b0, 16'h2923, 8'h41);
		xl_case(1'b1, 1'b0, 1'b1, 16'hF9A4, 8'h77);
		xl_case(1'b0, 1'b0, 1'b0, 16'h2923, 8'h2B);
		xl_case(1'b1, 1'b1, 1'b0, 16'h3001, 8'hFF);
		xl_case(1'b0, 1'b1, 1'b0, 16'hE000, 8'hFF);
		s_refuse();
		end_sim();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		fail_wait();
	end
endmodule
